// [hw/codec_gain_defs.svh]
// Offsets, field positions, reset values and timing counts of the gain bank.
`ifndef CODEC_GAIN_DEFS_SVH
`define CODEC_GAIN_DEFS_SVH

// Register page and offsets within that page.
`define GAIN_PAGE        4'h2
`define OFS_RECORD_GAIN  6'h01
`define OFS_PLAYBACK_GAIN 6'h02

// Record gain register field positions.
`define REC_MUTE_POS     15
`define REC_GAIN_MSB     14
`define REC_GAIN_LSB     8
`define REC_UPPER_MSB    15
`define REC_UPPER_LSB    8
`define TARGET_MSB       7
`define TARGET_LSB       5
`define TCONST_MSB       4
`define TCONST_LSB       1
`define LOOP_EN_POS      0

// Playback gain register field positions.
`define LEFT_MUTE_POS    15
`define LEFT_VOL_MSB     14
`define LEFT_VOL_LSB     8
`define RIGHT_MUTE_POS   7
`define RIGHT_VOL_MSB    6
`define RIGHT_VOL_LSB    0

// Reset values.
`define MUTE_RST         1'h1
`define REC_GAIN_RST     7'h00
`define TARGET_RST       3'h0
`define TCONST_RST       4'h0
`define LOOP_EN_RST      1'h0
`define VOLUME_RST       7'h7F

// Highest distinct record gain code, 59.5 dB in half-decibel steps.
`define REC_GAIN_MAX     7'h77

// Attack times in milliseconds: 8, 11, 16, 20.
`define ATTACK0_MS       10'h008
`define ATTACK1_MS       10'h00B
`define ATTACK2_MS       10'h010
`define ATTACK3_MS       10'h014
// Decay times in milliseconds: 100, 200, 400, 500.
`define DECAY0_MS        10'h064
`define DECAY1_MS        10'h0C8
`define DECAY2_MS        10'h190
`define DECAY3_MS        10'h1F4

// System clock period and the millisecond base of the loop timer.
`define CLK_PERIOD_NS    25
`define MS_TIME_NS       1000000
`define MS_CYCLES        (`MS_TIME_NS / `CLK_PERIOD_NS)

`endif

// [hw/codec_gain_pkg.sv]
// Types and helper functions shared by the gain bank modules.
package codec_gain_pkg;
    `include "codec_gain_defs.svh"

    // Record channel settings as seen by the analog front end.
    typedef struct packed {
        logic       record_mute_bit;
        logic [7:0] applied_gain;
        logic       loop_enable_bit;
        logic [2:0] loop_target_level;
    } record_t;

    // Playback channel settings.
    typedef struct packed {
        logic       left_playback_mute;
        logic [6:0] left_playback_volume;
        logic       right_playback_mute;
        logic [6:0] right_playback_volume;
    } playback_t;

    // Whole state of the register bank.
    typedef struct packed {
        logic        record_mute_bit;
        logic [6:0]  record_gain_field;
        logic [2:0]  loop_target_level;
        logic [3:0]  loop_time_constant;
        logic        loop_enable_bit;
        playback_t   play;
        logic [7:0]  applied_gain;
        logic [15:0] rd_data;
        logic        rd_valid;
    } bank_t;

    // Whole state of the loop timer.
    typedef struct packed {
        logic [15:0] base;
        logic [9:0]  attack_ms;
        logic [9:0]  decay_ms;
        logic        attack_tick;
        logic        decay_tick;
    } timer_t;

    // Turns a two-bit selector into attack or decay time in milliseconds.
    function automatic logic [9:0] time_ms(input logic [1:0] sel,
                                           input logic       decay);
        logic [9:0] ms;
        ms = 10'h000;
        case (sel)
            2'h0: ms = decay ? `DECAY0_MS : `ATTACK0_MS;
            2'h1: ms = decay ? `DECAY1_MS : `ATTACK1_MS;
            2'h2: ms = decay ? `DECAY2_MS : `ATTACK2_MS;
            default: ms = decay ? `DECAY3_MS : `ATTACK3_MS;
        endcase
        return ms;
    endfunction
endpackage

// [hw/loop_timer.sv]
// Attack and decay tick generator paced by the system clock.
`timescale 1ns/1ps
`include "codec_gain_defs.svh"
module loop_timer
    import codec_gain_pkg::*;
#(
    parameter int MS_CYCLES = `MS_CYCLES
) (
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Settings from the register bank.
    input  wire logic       enable,
    input  wire logic [3:0] tconst,
    // Tick outputs.
    output logic            attack_tick,
    output logic            decay_tick
);
    localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

    timer_t     st_r;       // Registered timer state.
    timer_t     st_nxt;     // Next timer state.
    logic       ms_hit;     // Last clock of one millisecond.
    logic [9:0] attack_lim; // Selected attack time.
    logic [9:0] decay_lim;  // Selected decay time.

    // Times are counted in system clocks, so they do not follow the sample rate.
    assign ms_hit     = (st_r.base == MS_LAST);
    assign attack_lim = time_ms(tconst[1:0], 1'b0);
    assign decay_lim  = time_ms(tconst[3:2], 1'b1);

    // Counts milliseconds and fires a tick when each selected time is reached.
    always_comb begin
        st_nxt             = st_r;
        st_nxt.attack_tick = 1'b0;
        st_nxt.decay_tick  = 1'b0;
        if (!enable) begin
            // Counters rest while the loop is off.
            st_nxt.base      = 16'h0000;
            st_nxt.attack_ms = 10'h000;
            st_nxt.decay_ms  = 10'h000;
        end else if (ms_hit) begin
            st_nxt.base = 16'h0000;
            // A setting shortened to or below the running count ends the period at the next millisecond end.
            if (st_r.attack_ms + 10'h001 >= attack_lim) begin
                st_nxt.attack_ms   = 10'h000;
                st_nxt.attack_tick = 1'b1;
            end else begin
                st_nxt.attack_ms = st_r.attack_ms + 10'h001;
            end
            if (st_r.decay_ms + 10'h001 >= decay_lim) begin
                st_nxt.decay_ms   = 10'h000;
                st_nxt.decay_tick = 1'b1;
            end else begin
                st_nxt.decay_ms = st_r.decay_ms + 10'h001;
            end
        end else begin
            st_nxt.base = st_r.base + 16'h0001;
        end
    end

    // Registers the timer state.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign attack_tick = st_r.attack_tick;
    assign decay_tick  = st_r.decay_tick;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // An attack tick closes a millisecond at which the count reached at least the selected time.
    a_attack_period: assert property (st_r.attack_tick |->
        $past(ms_hit) && ($past(st_r.attack_ms) + 10'h001 >= $past(attack_lim)))
        else $error("attack tick without its period");
    // A decay tick closes a millisecond at which the count reached at least the selected time.
    a_decay_period: assert property (st_r.decay_tick |->
        $past(ms_hit) && ($past(st_r.decay_ms) + 10'h001 >= $past(decay_lim)))
        else $error("decay tick without its period");
    c_attack_tick: cover property (st_r.attack_tick);
endmodule // loop_timer

// [hw/codec_gain_control.sv]
// Record and playback gain register bank with its loop timer.
`timescale 1ns/1ps
`include "codec_gain_defs.svh"
// Behaviour
// - Record mute bit silences record, resets set.
// - Record gain half-dB steps, clamps at 59.5.
// - Loop on: upper byte reads loop gain.
// - Target level selects loop aim, resets 000.
// - Time constant selects attack and decay times.
// - Loop times independent of sample rate.
// - Enable bit hands gain to loop.
// - Left mute bit silences left, resets set.
// - Left volume attenuates, resets all ones.
// - Right mute bit silences right, resets set.
// - Right volume attenuates, resets all ones.
// - Both registers on page two, offsets 1,2.
module codec_gain_control
    import codec_gain_pkg::*;
#(
    parameter int MS_CYCLES = `MS_CYCLES
) (
    // Clock and reset.
    input  wire logic        CLK_SYS,
    input  wire logic        RST,
    // Register access port.
    input  wire logic [3:0]  REG_PAGE,
    input  wire logic [5:0]  REG_ADDR,
    input  wire logic        REG_WR,
    input  wire logic [15:0] REG_WDATA,
    input  wire logic        REG_RD,
    output logic [15:0]      REG_RDATA,
    output logic             REG_RVALID,
    // Gain currently applied by the automatic loop.
    input  wire logic [7:0]  AGC_GAIN,
    // Settings to the channels.
    output record_t          REC_OUT,
    output playback_t        PLAY_OUT,
    output logic [3:0]       LOOP_TIME_CONSTANT,
    output logic             ATTACK_TICK,
    output logic             DECAY_TICK
);
    bank_t st_r;     // Registered bank state.
    bank_t st_nxt;   // Next bank state.
    logic  hit_rec;  // Access addresses the record gain register.
    logic  hit_play; // Access addresses the playback gain register.

    // Clamps the stored record gain code to the top distinct step.
    function automatic logic [7:0] clamp_gain(input logic [6:0] code);
        return (code > `REC_GAIN_MAX) ? {1'b0, `REC_GAIN_MAX} : {1'b0, code};
    endfunction

    // Decodes page and offset; other pages belong to other blocks.
    always_comb begin
        hit_rec  = 1'b0;
        hit_play = 1'b0;
        if (REG_PAGE != `GAIN_PAGE) begin
            hit_rec  = 1'b0;
        end else if (REG_ADDR == `OFS_RECORD_GAIN) begin
            hit_rec  = 1'b1;
        end else if (REG_ADDR == `OFS_PLAYBACK_GAIN) begin
            hit_play = 1'b1;
        end
    end

    // Computes the next bank state from writes, reads and the loop gain.
    always_comb begin
        st_nxt          = st_r;
        st_nxt.rd_valid = 1'b0;
        if (REG_WR && hit_rec) begin
            // While the loop runs, the upper byte is read only.
            if (!st_r.loop_enable_bit) begin
                st_nxt.record_mute_bit   = REG_WDATA[`REC_MUTE_POS];
                st_nxt.record_gain_field =
                    REG_WDATA[`REC_GAIN_MSB:`REC_GAIN_LSB];
            end
            st_nxt.loop_target_level  =
                REG_WDATA[`TARGET_MSB:`TARGET_LSB];
            st_nxt.loop_time_constant =
                REG_WDATA[`TCONST_MSB:`TCONST_LSB];
            st_nxt.loop_enable_bit    = REG_WDATA[`LOOP_EN_POS];
        end else if (REG_WR && hit_play) begin
            st_nxt.play.left_playback_mute    =
                REG_WDATA[`LEFT_MUTE_POS];
            st_nxt.play.left_playback_volume  =
                REG_WDATA[`LEFT_VOL_MSB:`LEFT_VOL_LSB];
            st_nxt.play.right_playback_mute   =
                REG_WDATA[`RIGHT_MUTE_POS];
            st_nxt.play.right_playback_volume =
                REG_WDATA[`RIGHT_VOL_MSB:`RIGHT_VOL_LSB];
        end
        // The applied gain follows the loop or the programmed field.
        if (st_nxt.loop_enable_bit) begin
            st_nxt.applied_gain = AGC_GAIN;
        end else begin
            st_nxt.applied_gain = clamp_gain(st_nxt.record_gain_field);
        end
        // A read answers one clock later; unmapped offsets read zero.
        if (REG_RD) begin
            st_nxt.rd_valid = 1'b1;
            if (hit_rec) begin
                if (st_r.loop_enable_bit) begin
                    st_nxt.rd_data[`REC_UPPER_MSB:`REC_UPPER_LSB] =
                        AGC_GAIN;
                end else begin
                    st_nxt.rd_data[`REC_UPPER_MSB:`REC_UPPER_LSB] =
                        {st_r.record_mute_bit, st_r.record_gain_field};
                end
                st_nxt.rd_data[`TARGET_MSB:0] = {st_r.loop_target_level,
                    st_r.loop_time_constant, st_r.loop_enable_bit};
            end else if (hit_play) begin
                st_nxt.rd_data = st_r.play;
            end else begin
                st_nxt.rd_data = 16'h0000;
            end
        end
    end

    // Registers the bank state; reset loads the documented defaults.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            st_r                            <= '0;
            st_r.record_mute_bit            <= `MUTE_RST;
            st_r.record_gain_field          <= `REC_GAIN_RST;
            st_r.loop_target_level          <= `TARGET_RST;
            st_r.loop_time_constant         <= `TCONST_RST;
            st_r.loop_enable_bit            <= `LOOP_EN_RST;
            st_r.play.left_playback_mute    <= `MUTE_RST;
            st_r.play.left_playback_volume  <= `VOLUME_RST;
            st_r.play.right_playback_mute   <= `MUTE_RST;
            st_r.play.right_playback_volume <= `VOLUME_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Drives the channel settings straight from the bank flops.
    assign REC_OUT = '{record_mute_bit:   st_r.record_mute_bit,
                       applied_gain:      st_r.applied_gain,
                       loop_enable_bit:   st_r.loop_enable_bit,
                       loop_target_level: st_r.loop_target_level};
    assign PLAY_OUT                  = st_r.play;
    assign LOOP_TIME_CONSTANT        = st_r.loop_time_constant;
    assign REG_RDATA                 = st_r.rd_data;
    assign REG_RVALID                = st_r.rd_valid;

    // Paces the loop in real time, whatever the record sample rate.
    loop_timer #(
        .MS_CYCLES (MS_CYCLES)
    ) loop_timer_inst (
        .clk_sys     (CLK_SYS),
        .rst         (RST),
        .enable      (st_r.loop_enable_bit),
        .tconst      (st_r.loop_time_constant),
        .attack_tick (ATTACK_TICK),
        .decay_tick  (DECAY_TICK)
    );

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    // Mute bits come out of reset set and volumes at full cut.
    a_reset_defaults: assert property ($past(RST) |->
        st_r.record_mute_bit && st_r.play.left_playback_mute &&
        st_r.play.right_playback_mute &&
        st_r.play.left_playback_volume == 7'h7F &&
        st_r.play.right_playback_volume == 7'h7F &&
        !st_r.loop_enable_bit && st_r.loop_target_level == 3'h0)
        else $error("reset defaults wrong");
    // A record write with the loop off stores mute and gain.
    a_rec_write: assert property (REG_WR && hit_rec && !st_r.loop_enable_bit
        |=> st_r.record_mute_bit == $past(REG_WDATA[15]) &&
            st_r.record_gain_field == $past(REG_WDATA[14:8]))
        else $error("record write not stored");
    // Programmed gain saturates at 59.5 dB.
    a_gain_clamp: assert property (!st_r.loop_enable_bit |->
        st_r.applied_gain == ((st_r.record_gain_field > 7'h77) ?
            8'h77 : {1'b0, st_r.record_gain_field}))
        else $error("record gain not clamped");
    // With the loop on, reads show the loop gain in the upper byte.
    a_loop_read: assert property (REG_RD && hit_rec && st_r.loop_enable_bit
        |=> REG_RVALID && REG_RDATA[15:8] == $past(AGC_GAIN))
        else $error("loop gain not read back");
    // Target, time constant and enable follow a record write.
    a_ctrl_write: assert property (REG_WR && hit_rec |=>
        st_r.loop_target_level == $past(REG_WDATA[7:5]) &&
        st_r.loop_time_constant == $past(REG_WDATA[4:1]) &&
        st_r.loop_enable_bit == $past(REG_WDATA[0]))
        else $error("loop settings not stored");
    // With the loop on, the applied gain tracks the loop.
    a_loop_gain: assert property (REG_WR && hit_rec && REG_WDATA[0] |=>
        REC_OUT.applied_gain == $past(AGC_GAIN))
        else $error("applied gain not from loop");
    // Left playback settings follow a playback write.
    a_left_write: assert property (REG_WR && hit_play |=>
        PLAY_OUT.left_playback_mute == $past(REG_WDATA[15]) &&
        PLAY_OUT.left_playback_volume == $past(REG_WDATA[14:8]))
        else $error("left playback not stored");
    // Right playback settings follow a playback write.
    a_right_write: assert property (REG_WR && hit_play |=>
        PLAY_OUT.right_playback_mute == $past(REG_WDATA[7]) &&
        PLAY_OUT.right_playback_volume == $past(REG_WDATA[6:0]))
        else $error("right playback not stored");
    // Writes to other pages leave the bank alone.
    a_page_decode: assert property (REG_WR && REG_PAGE != 4'h2 |=>
        $stable(st_r.play) && $stable(st_r.loop_time_constant))
        else $error("foreign page write taken");
    // While the loop runs, gain writes are ignored.
    a_loop_hold: assert property (REG_WR && hit_rec && st_r.loop_enable_bit
        |=> $stable(st_r.record_gain_field))
        else $error("gain written while loop on");

    // Unmapped offsets and foreign pages read back as zero.
    a_unmapped_read: assert property (REG_RD && !hit_rec && !hit_play
        |=> REG_RVALID && REG_RDATA == 16'h0000)
        else $error("unmapped read not zero");
    // Playback writes leave the record settings alone.
    a_play_apart: assert property (REG_WR && hit_play |=>
        $stable(st_r.record_gain_field) && $stable(st_r.loop_enable_bit))
        else $error("playback write changed record settings");

    // Main scenarios reached by the bench.
    c_loop_read: cover property (REG_RD && hit_rec && st_r.loop_enable_bit);
    c_gain_clamp: cover property (st_r.record_gain_field > 7'h77);
    c_play_write: cover property (REG_WR && hit_play);
    c_loop_hold: cover property (REG_WR && hit_rec && st_r.loop_enable_bit);
endmodule // codec_gain_control

// [verif/codec_gain_control_tb_top.sv]
// Self-checking testbench of the record and playback gain register bank.
`timescale 1ns/1ps
module codec_gain_control_tb_top
    import codec_gain_pkg::*;
;
    localparam int MS = 10;           // Shortened millisecond for the run.
    logic        CLK_SYS   = 1'b0;    // System clock, 40 MHz.
    logic        RST       = 1'b1;    // Synchronous reset, active high.
    logic [3:0]  REG_PAGE  = 4'h0;    // Page of the access.
    logic [5:0]  REG_ADDR  = 6'h00;   // Offset within the page.
    logic        REG_WR    = 1'b0;    // Write strobe.
    logic [15:0] REG_WDATA = 16'h0000; // Write data.
    logic        REG_RD    = 1'b0;    // Read strobe.
    logic [15:0] REG_RDATA;           // Read data.
    logic        REG_RVALID;          // Read answer strobe.
    logic [7:0]  AGC_GAIN  = 8'h00;   // Gain reported by the loop.
    record_t     REC_OUT;             // Record channel settings.
    playback_t   PLAY_OUT;            // Playback channel settings.
    logic [3:0]  LOOP_TIME_CONSTANT;  // Time constant setting.
    logic        ATTACK_TICK;         // Attack pacing pulse.
    logic        DECAY_TICK;          // Decay pacing pulse.
    int          error_cnt = 0;       // Mismatches seen.
    int          check_count = 0;     // Comparisons made.
    int          att_ms[4] = '{8, 11, 16, 20};    // Attack times.
    int          dec_ms[4] = '{100, 200, 400, 500}; // Decay times.

    // Half period of 12.5 ns gives the 25 ns clock.
    always #12.5 CLK_SYS = ~CLK_SYS;

    codec_gain_control #(.MS_CYCLES(MS)) codec_gain_control_inst (
        .CLK_SYS(CLK_SYS), .RST(RST), .REG_PAGE(REG_PAGE),
        .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
        .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
        .AGC_GAIN(AGC_GAIN), .REC_OUT(REC_OUT), .PLAY_OUT(PLAY_OUT),
        .LOOP_TIME_CONSTANT(LOOP_TIME_CONSTANT),
        .ATTACK_TICK(ATTACK_TICK), .DECAY_TICK(DECAY_TICK));

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Compares a seen value with the expected one and counts both.
    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One write strobe, then one spare edge so registered outputs settle.
    task automatic wr(input logic [3:0] p, input logic [5:0] a,
                      input logic [15:0] d);
        @(posedge CLK_SYS);
        REG_PAGE  <= p;
        REG_ADDR  <= a;
        REG_WDATA <= d;
        REG_WR    <= 1'b1;
        @(posedge CLK_SYS);
        REG_WR <= 1'b0;
        @(posedge CLK_SYS);
        #1;
    endtask

    // One read strobe; the answer pulse must last exactly one cycle.
    task automatic rd(input logic [3:0] p, input logic [5:0] a,
                      output logic [15:0] d);
        @(posedge CLK_SYS);
        REG_PAGE <= p;
        REG_ADDR <= a;
        REG_RD   <= 1'b1;
        @(posedge CLK_SYS);
        REG_RD <= 1'b0;
        #1;
        chk("read valid", {15'h0000, REG_RVALID}, 16'h0001);
        d = REG_RDATA;
        @(posedge CLK_SYS);
        #1;
        chk("read valid end", {15'h0000, REG_RVALID}, 16'h0000);
    endtask

    // Waits a bounded number of cycles for the next attack or decay tick.
    task automatic wait_tick(input logic dec, output int cyc);
        cyc = 0;
        while (1) begin
            @(posedge CLK_SYS);
            #1;
            cyc++;
            if ((dec ? DECAY_TICK : ATTACK_TICK) === 1'b1) begin
                return;
            end
            if (cyc >= 6000) begin
                error_cnt++;
                $display("wrong value tick wait expected tick seen none");
                results();
            end
        end
    endtask

    // Reset values at the outputs and through reads.
    task automatic test_reset();
        logic [15:0] d;
        chk("rec mute", {15'h0000, REC_OUT.record_mute_bit}, 16'h0001);
        chk("applied", {8'h00, REC_OUT.applied_gain}, 16'h0000);
        chk("target", {13'h0000, REC_OUT.loop_target_level}, 16'h0000);
        chk("tconst", {12'h000, LOOP_TIME_CONSTANT}, 16'h0000);
        chk("enable", {15'h0000, REC_OUT.loop_enable_bit}, 16'h0000);
        chk("ticks", {14'h0000, ATTACK_TICK, DECAY_TICK}, 16'h0000);
        chk("play out", PLAY_OUT, 16'hFFFF);
        rd(4'h2, 6'h01, d);
        chk("rec word", d, 16'h8000);
        rd(4'h2, 6'h02, d);
        chk("play word", d, 16'hFFFF);
        $display("test reset done");
    endtask

    // Playback fields and refusal of foreign pages and offsets.
    task automatic test_playback();
        logic [15:0] d;
        wr(4'h2, 6'h02, 16'h3A45);
        chk("play out", PLAY_OUT, 16'h3A45);
        rd(4'h2, 6'h02, d);
        chk("play word", d, 16'h3A45);
        wr(4'h1, 6'h02, 16'h8080);
        wr(4'h2, 6'h03, 16'h8080);
        wr(4'h2, 6'h00, 16'h8080);
        chk("play kept", PLAY_OUT, 16'h3A45);
        rd(4'h2, 6'h03, d);
        chk("unmapped", d, 16'h0000);
        rd(4'h0, 6'h01, d);
        chk("other page", d, 16'h0000);
        wr(4'h2, 6'h02, 16'h7F00);
        chk("play edges", PLAY_OUT, 16'h7F00);
        $display("test playback done");
    endtask

    // Record gain codes around the clamp, with mute and lower fields.
    task automatic test_record();
        logic [15:0] d;
        logic [6:0]  g[5] = '{7'h00, 7'h05, 7'h77, 7'h78, 7'h7F};
        logic [6:0]  e[5] = '{7'h00, 7'h05, 7'h77, 7'h77, 7'h77};
        for (int i = 0; i < 5; i++) begin
            wr(4'h2, 6'h01, {1'b0, g[i], 3'h5, 4'hA, 1'b0});
            chk("applied", {8'h00, REC_OUT.applied_gain},
                {9'h000, e[i]});
            chk("mute", {15'h0000, REC_OUT.record_mute_bit}, 16'h0000);
            chk("target", {13'h0000, REC_OUT.loop_target_level},
                16'h0005);
            chk("tconst", {12'h000, LOOP_TIME_CONSTANT}, 16'h000A);
            rd(4'h2, 6'h01, d);
            chk("rec word", d, {1'b0, g[i], 8'hB4});
        end
        wr(4'h2, 6'h01, 16'h8500);
        chk("mute", {15'h0000, REC_OUT.record_mute_bit}, 16'h0001);
        chk("applied", {8'h00, REC_OUT.applied_gain}, 16'h0005);
        $display("test record done");
    endtask

    // Loop hand-over, loop gain reads, protected upper byte, targets.
    task automatic test_loop();
        logic [15:0] d;
        @(posedge CLK_SYS);
        AGC_GAIN <= 8'hE8;
        wr(4'h2, 6'h01, 16'h10E7);
        chk("enable", {15'h0000, REC_OUT.loop_enable_bit}, 16'h0001);
        chk("applied", {8'h00, REC_OUT.applied_gain}, 16'h00E8);
        rd(4'h2, 6'h01, d);
        chk("loop low", d, 16'hE8E7);
        @(posedge CLK_SYS);
        AGC_GAIN <= 8'h77;
        rd(4'h2, 6'h01, d);
        chk("loop high", d, 16'h77E7);
        for (int t = 0; t < 8; t++) begin
            wr(4'h2, 6'h01, {8'hFF, t[2:0], 4'h3, 1'b1});
            chk("target", {13'h0000, REC_OUT.loop_target_level},
                {13'h0000, t[2:0]});
            chk("applied", {8'h00, REC_OUT.applied_gain}, 16'h0077);
        end
        wr(4'h2, 6'h01, 16'hFF00);
        rd(4'h2, 6'h01, d);
        chk("stored gain", d, 16'h1000);
        chk("applied", {8'h00, REC_OUT.applied_gain}, 16'h0010);
        $display("test loop done");
    endtask

    // Tick spacing for every attack and decay selection.
    task automatic test_timer();
        int n;
        for (int i = 0; i < 4; i++) begin
            wr(4'h2, 6'h01, 16'h0000);
            wr(4'h2, 6'h01, {8'h00, 3'h0, i[1:0], i[1:0], 1'b1});
            wait_tick(1'b0, n);
            wait_tick(1'b0, n);
            chk("attack", n[15:0], 16'(att_ms[i] * MS));
            wait_tick(1'b1, n);
            wait_tick(1'b1, n);
            chk("decay", n[15:0], 16'(dec_ms[i] * MS));
        end
        wr(4'h2, 6'h01, 16'h0000);
        for (int c = 0; c < 300; c++) begin
            @(posedge CLK_SYS);
            #1;
            if (ATTACK_TICK !== 1'b0 || DECAY_TICK !== 1'b0) begin
                chk("idle ticks", {14'h0000, ATTACK_TICK, DECAY_TICK},
                    16'h0000);
            end
        end
        $display("test timer done");
    endtask

    // Main sequence: reset for ten cycles, then each scenario in turn.
    initial begin
        repeat (10) @(posedge CLK_SYS);
        RST <= 1'b0;
        @(posedge CLK_SYS);
        #1;
        test_reset();
        test_playback();
        test_record();
        test_loop();
        test_timer();
        results();
    end
endmodule // codec_gain_control_tb_top
